// ### rtl/cai_pkg.sv
// Shared constants, types and helpers of the arithmetic and pointer datapath.
package cai_pkg;
  // Register bus map, byte addresses.
  localparam logic [10:0] CAI_OFS_CMD = 11'h000;
  localparam logic [10:0] CAI_OFS_ACC = 11'h004;
  localparam logic [10:0] CAI_OFS_FLAG = 11'h008;
  localparam logic [10:0] CAI_OFS_STAT = 11'h00C;
  localparam int CAI_MEM_SEL_BIT = 10;
  // Direct address space locations.
  localparam logic [7:0] CAI_ADDR_WIN = 8'h0E;
  localparam logic [7:0] CAI_ADDR_PTR = 8'h0F;
  localparam logic [7:0] CAI_ZERO = 8'h00;
  localparam logic [7:0] CAI_ONE = 8'h01;
  // Reset values.
  localparam logic [7:0] CAI_ACC_RST = 8'h00;
  localparam logic [1:0] CAI_FLAG_RST = 2'h0;
  localparam logic [7:0] CAI_MEM_RST = 8'h00;
  // Flag and status bit positions.
  localparam int CAI_FLAG_C = 0;
  localparam int CAI_FLAG_Z = 1;
  localparam int CAI_STAT_UNIMP = 0;
  // Opcode groups decoded from the top bits.
  localparam logic [2:0] CAI_GRP_TINY0 = 3'h0;
  localparam logic [2:0] CAI_GRP_TINY1 = 3'h1;
  localparam logic [2:0] CAI_GRP_CLR_S = 3'h2;
  localparam logic [2:0] CAI_GRP_LDA_S = 3'h3;
  localparam logic [2:0] CAI_GRP_STA_S = 3'h4;
  // Full opcodes; all but the three accumulator forms take operand bytes.
  localparam logic [7:0] CAI_OP_ADC_IMM = 8'hA0;
  localparam logic [7:0] CAI_OP_ADC_DIR = 8'hA1;
  localparam logic [7:0] CAI_OP_ADD_IMM = 8'hA2;
  localparam logic [7:0] CAI_OP_ADD_DIR = 8'hA3;
  localparam logic [7:0] CAI_OP_SUB_IMM = 8'hA4;
  localparam logic [7:0] CAI_OP_SUB_DIR = 8'hA5;
  localparam logic [7:0] CAI_OP_INC_DIR = 8'hA6;
  localparam logic [7:0] CAI_OP_DEC_DIR = 8'hA7;
  localparam logic [7:0] CAI_OP_CLR_DIR = 8'hA8;
  localparam logic [7:0] CAI_OP_LDA_IMM = 8'hA9;
  localparam logic [7:0] CAI_OP_LDA_DIR = 8'hAA;
  localparam logic [7:0] CAI_OP_STA_DIR = 8'hAB;
  localparam logic [7:0] CAI_OP_MOV_DD = 8'hAC;
  localparam logic [7:0] CAI_OP_MOV_ID = 8'hAD;
  localparam logic [7:0] CAI_OP_INC_ACC = 8'hAE;
  localparam logic [7:0] CAI_OP_DEC_ACC = 8'hAF;
  localparam logic [7:0] CAI_OP_CLR_ACC = 8'hB0;

  typedef enum logic [2:0] {CAI_ALU_ADD, CAI_ALU_ADC, CAI_ALU_SUB, CAI_ALU_INC,
                            CAI_ALU_DEC, CAI_ALU_CLR, CAI_ALU_PASS} cai_alu_e;
  typedef enum logic [1:0] {CAI_B_IMM, CAI_B_MEM, CAI_B_ACC} cai_bsel_e;
  typedef enum logic [1:0] {CAI_IDLE, CAI_EXEC, CAI_ACK} cai_state_e;

  // The window location stands for the byte that the pointer names.
  function automatic logic [7:0] cai_resolve(input logic [7:0] addr, input logic [7:0] ptr);
    cai_resolve = (addr == CAI_ADDR_WIN) ? ptr : addr;
  endfunction
endpackage

// ### rtl/cai_alu.sv
// Eight-bit arithmetic unit: add, add with carry, subtract, step, clear, pass.
`timescale 1ns/1ps
module cai_alu import cai_pkg::*; (
  // Operation select
  input wire cai_alu_e op,
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  // Result
  output logic [7:0] res,
  output logic cout
);
  logic [8:0] sum;

  always_comb begin
    sum = {1'b0, b};
    unique case (op)
      CAI_ALU_ADD: sum = {1'b0, a} + {1'b0, b};
      CAI_ALU_ADC: sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      // Bit eight of the difference is the borrow.
      CAI_ALU_SUB: sum = {1'b0, a} - {1'b0, b};
      CAI_ALU_INC: sum = {1'b0, a} + {1'b0, CAI_ONE};
      CAI_ALU_DEC: sum = {1'b0, a} - {1'b0, CAI_ONE};
      CAI_ALU_CLR: sum = {1'b0, CAI_ZERO};
      CAI_ALU_PASS: sum = {1'b0, b};
    endcase
    res = sum[7:0];
    cout = sum[8];
  end
endmodule

// ### rtl/cai_mem.sv
// Direct address space storage with the pointer byte exported.
`timescale 1ns/1ps
module cai_mem import cai_pkg::*; #(
  parameter int DEPTH = 256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [7:0] raddr,
  output logic [7:0] rdata,
  // Pointer byte
  output logic [7:0] ptr
);
  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= CAI_MEM_RST;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  assign rdata = mem_r[raddr];
  assign ptr = mem_r[CAI_ADDR_PTR];
endmodule

// ### rtl/cai_core.sv
// Arithmetic and pointer datapath core with an Avalon-MM register slave.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cai_core import cai_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  cai_state_e state_r;
  logic [7:0] acc_r;
  logic [1:0] flag_r;
  logic unimp_r;
  logic [7:0] op_r;
  logic [7:0] opa_r;
  logic [7:0] opb_r;

  // Decoded instruction fields.
  cai_alu_e d_op;
  logic d_a_mem;
  cai_bsel_e d_bsel;
  logic [7:0] d_raddr;
  logic [7:0] d_waddr;
  logic d_wr_acc;
  logic d_wr_mem;
  logic d_legal;

  logic [7:0] mem_rdata;
  logic [7:0] ptr;
  logic [7:0] mem_raddr;
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_cout;

  logic bus_req;
  logic bus_mem;
  logic [7:0] bus_idx;
  logic bus_wr_ok;
  logic [31:0] rd_val;
  logic bus_cmd;
  logic reg_wr_acc;
  logic reg_wr_flag;
  logic reg_wr_stat;

  assign bus_req = avs_read | avs_write;
  assign bus_mem = avs_address[CAI_MEM_SEL_BIT];
  assign bus_idx = avs_address[9:2];
  // Only the low byte lane enable is decoded, so a write without it is answered but ignored.
  assign bus_wr_ok = avs_write & avs_byteenable[0];
  // A command write is the only access that needs an execute cycle before its answer.
  assign bus_cmd = bus_wr_ok & !bus_mem & (avs_address == CAI_OFS_CMD);
  // Register writes land in the answer cycle, so they never meet an executing instruction.
  assign reg_wr_acc = (state_r == CAI_ACK) & bus_wr_ok & !bus_mem & (avs_address == CAI_OFS_ACC);
  assign reg_wr_flag = (state_r == CAI_ACK) & bus_wr_ok & !bus_mem & (avs_address == CAI_OFS_FLAG);
  assign reg_wr_stat = (state_r == CAI_ACK) & bus_wr_ok & !bus_mem & (avs_address == CAI_OFS_STAT) &
                       avs_writedata[CAI_STAT_UNIMP];

  // Instruction decode. Anything not listed is unimplemented.
  always_comb begin
    d_op = CAI_ALU_PASS;
    d_a_mem = 1'b0;
    d_bsel = CAI_B_ACC;
    d_raddr = opa_r;
    d_waddr = opa_r;
    d_wr_acc = 1'b0;
    d_wr_mem = 1'b0;
    d_legal = 1'b1;
    case (op_r[7:5])
      CAI_GRP_TINY0, CAI_GRP_TINY1: begin
        // Single-byte forms whose low nibble is the address.
        d_raddr = {4'h0, op_r[3:0]};
        d_waddr = {4'h0, op_r[3:0]};
        unique case (op_r[5:4])
          2'h0: begin
            d_op = CAI_ALU_INC;
            d_a_mem = 1'b1;
            d_wr_mem = 1'b1;
          end
          2'h1: begin
            d_op = CAI_ALU_DEC;
            d_a_mem = 1'b1;
            d_wr_mem = 1'b1;
          end
          2'h2: begin
            d_op = CAI_ALU_ADD;
            d_bsel = CAI_B_MEM;
            d_wr_acc = 1'b1;
          end
          2'h3: begin
            d_op = CAI_ALU_SUB;
            d_bsel = CAI_B_MEM;
            d_wr_acc = 1'b1;
          end
        endcase
      end
      CAI_GRP_CLR_S: begin
        d_op = CAI_ALU_CLR;
        d_waddr = {3'h0, op_r[4:0]};
        d_wr_mem = 1'b1;
      end
      CAI_GRP_LDA_S: begin
        d_raddr = {3'h0, op_r[4:0]};
        d_bsel = CAI_B_MEM;
        d_wr_acc = 1'b1;
      end
      CAI_GRP_STA_S: begin
        d_waddr = {3'h0, op_r[4:0]};
        d_wr_mem = 1'b1;
      end
      default: begin
        case (op_r)
          CAI_OP_ADC_IMM, CAI_OP_ADC_DIR: begin
            d_op = CAI_ALU_ADC;
            d_bsel = op_r[0] ? CAI_B_MEM : CAI_B_IMM;
            d_wr_acc = 1'b1;
          end
          CAI_OP_ADD_IMM, CAI_OP_ADD_DIR: begin
            d_op = CAI_ALU_ADD;
            d_bsel = op_r[0] ? CAI_B_MEM : CAI_B_IMM;
            d_wr_acc = 1'b1;
          end
          CAI_OP_SUB_IMM, CAI_OP_SUB_DIR: begin
            d_op = CAI_ALU_SUB;
            d_bsel = op_r[0] ? CAI_B_MEM : CAI_B_IMM;
            d_wr_acc = 1'b1;
          end
          CAI_OP_INC_DIR, CAI_OP_DEC_DIR: begin
            d_op = op_r[0] ? CAI_ALU_DEC : CAI_ALU_INC;
            d_a_mem = 1'b1;
            d_wr_mem = 1'b1;
          end
          CAI_OP_CLR_DIR: begin
            d_op = CAI_ALU_CLR;
            d_wr_mem = 1'b1;
          end
          CAI_OP_LDA_IMM, CAI_OP_LDA_DIR: begin
            d_bsel = op_r[0] ? CAI_B_IMM : CAI_B_MEM;
            d_wr_acc = 1'b1;
          end
          CAI_OP_STA_DIR: begin
            d_wr_mem = 1'b1;
          end
          CAI_OP_MOV_DD: begin
            d_bsel = CAI_B_MEM;
            d_waddr = opb_r;
            d_wr_mem = 1'b1;
          end
          CAI_OP_MOV_ID: begin
            d_bsel = CAI_B_IMM;
            d_waddr = opb_r;
            d_wr_mem = 1'b1;
          end
          CAI_OP_INC_ACC: d_op = CAI_ALU_INC;
          CAI_OP_DEC_ACC: d_op = CAI_ALU_DEC;
          CAI_OP_CLR_ACC: d_op = CAI_ALU_CLR;
          // Stack, multiply, divide and nibble exchange have no datapath here.
          default: d_legal = 1'b0;
        endcase
        // Accumulator-only forms write the result back in place.
        if (op_r == CAI_OP_INC_ACC || op_r == CAI_OP_DEC_ACC || op_r == CAI_OP_CLR_ACC) begin
          d_wr_acc = 1'b1;
        end
      end
    endcase
  end

  // The immediate of a move to memory is its first operand; others use it too.
  assign alu_a = d_a_mem ? mem_rdata : acc_r;
  always_comb begin
    unique case (d_bsel)
      CAI_B_IMM: alu_b = opa_r;
      CAI_B_MEM: alu_b = mem_rdata;
      CAI_B_ACC: alu_b = acc_r;
      default: alu_b = acc_r;
    endcase
  end

  cai_alu u_alu (
    .op(d_op),
    .a(alu_a),
    .b(alu_b),
    .cin(flag_r[CAI_FLAG_C]),
    .res(alu_res),
    .cout(alu_cout)
  );

  // Window addresses resolve through the pointer on both the bus and the core path.
  always_comb begin
    mem_raddr = cai_resolve(bus_idx, ptr);
    mem_we = 1'b0;
    mem_waddr = cai_resolve(bus_idx, ptr);
    mem_wdata = avs_writedata[7:0];
    if (state_r == CAI_EXEC) begin
      mem_raddr = cai_resolve(d_raddr, ptr);
      mem_waddr = cai_resolve(d_waddr, ptr);
      mem_wdata = alu_res;
      // An unimplemented code keeps its decode defaults, so it is kept off the write port.
      mem_we = d_legal & d_wr_mem;
    end else if (state_r == CAI_ACK) begin
      mem_we = bus_wr_ok & bus_mem;
    end
  end

  // Full depth is kept so that every direct address has a byte behind it.
  cai_mem #(
    .DEPTH(256)
  ) u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .ptr(ptr)
  );

  // Bus sequencer: one cycle to look, an execute cycle for commands only, one answer cycle with waitrequest low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= CAI_IDLE;
    end else begin
      unique case (state_r)
        CAI_IDLE: begin
          if (bus_req) begin
            state_r <= bus_cmd ? CAI_EXEC : CAI_ACK;
          end
        end
        CAI_EXEC: state_r <= CAI_ACK;
        CAI_ACK: state_r <= CAI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      // Dropping wait at the taking edge itself, or one edge later for a command, keeps the answer fully registered.
      avs_waitrequest <= !((state_r == CAI_IDLE && bus_req && !bus_cmd) || state_r == CAI_EXEC);
    end
  end

  // Instruction capture from the command word.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_r <= CAI_ZERO;
      opa_r <= CAI_ZERO;
      opb_r <= CAI_ZERO;
    end else if (state_r == CAI_IDLE && bus_cmd) begin
      op_r <= avs_writedata[7:0];
      opa_r <= avs_writedata[15:8];
      opb_r <= avs_writedata[23:16];
    end
  end

  // Read data, captured while the request is first seen.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (bus_mem) begin
      rd_val = {24'h00_0000, mem_rdata};
    end else begin
      case (avs_address)
        CAI_OFS_CMD: rd_val = {8'h00, opb_r, opa_r, op_r};
        CAI_OFS_ACC: rd_val = {24'h00_0000, acc_r};
        CAI_OFS_FLAG: rd_val = {30'h0000_0000, flag_r};
        CAI_OFS_STAT: rd_val = {31'h0000_0000, unimp_r};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (state_r == CAI_IDLE && avs_read) begin
      avs_readdata <= rd_val;
    end
  end

  // Accumulator.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= CAI_ACC_RST;
    end else if (state_r == CAI_EXEC && d_legal && d_wr_acc) begin
      acc_r <= alu_res;
    end else if (reg_wr_acc) begin
      acc_r <= avs_writedata[7:0];
    end
  end

  // Two flags only; loads, stores and transfers leave them alone.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= CAI_FLAG_RST;
    end else if (state_r == CAI_EXEC && d_legal && d_op != CAI_ALU_PASS) begin
      flag_r[CAI_FLAG_Z] <= (alu_res == CAI_ZERO);
      if (d_op == CAI_ALU_ADD || d_op == CAI_ALU_ADC || d_op == CAI_ALU_SUB) begin
        flag_r[CAI_FLAG_C] <= alu_cout;
      end
    end else if (reg_wr_flag) begin
      flag_r <= avs_writedata[1:0];
    end
  end

  // Unimplemented-opcode sticky bit; write one to clear, a new event wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unimp_r <= 1'b0;
    end else if (state_r == CAI_EXEC && !d_legal) begin
      unimp_r <= 1'b1;
    end else if (reg_wr_stat) begin
      unimp_r <= 1'b0;
    end
  end
endmodule

// ### bench/cai_core_checker.sv
// Checker on the slave port of the arithmetic and pointer datapath core.
`timescale 1ns/1ps
module cai_core_checker import cai_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic cmd_w;
  assign cmd_w = avs_write && avs_address == CAI_OFS_CMD && avs_byteenable[0];
  a_read_answer: assert property ($rose(avs_read) |=> !avs_waitrequest)
    else $error("read not answered after one cycle");
  a_write_answer: assert property ($rose(avs_write) && !cmd_w |=> !avs_waitrequest)
    else $error("write not answered after one cycle");
  a_cmd_answer: assert property ($rose(avs_write) && cmd_w |=> avs_waitrequest ##1 !avs_waitrequest)
    else $error("command not answered after two cycles");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_flag_two_bits: assert property (!avs_waitrequest && avs_read && avs_address == CAI_OFS_FLAG
    |-> avs_readdata[31:2] == 30'h00000000)
    else $error("flag register shows more than two flags");
  a_stat_one_bit: assert property (!avs_waitrequest && avs_read && avs_address == CAI_OFS_STAT
    |-> avs_readdata[31:1] == 31'h00000000)
    else $error("status shows unexpected bits");
  a_mem_byte_wide: assert property (!avs_waitrequest && avs_read && avs_address[10]
    |-> avs_readdata[31:8] == 24'h000000)
    else $error("memory read wider than a byte");
  c_cmd: cover property ($rose(avs_write) && cmd_w);
  c_win_read: cover property (!avs_waitrequest && avs_read && avs_address == {1'b1, CAI_ADDR_WIN, 2'b00});
  c_flag_read: cover property (!avs_waitrequest && avs_read && avs_address == CAI_OFS_FLAG);
endmodule

bind cai_core cai_core_checker i_chk (
  .clk(clk),
  .rst_b(rst_b),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest)
);

// ### bench/cai_core_tb.sv
// Self-checking bench for the arithmetic and pointer datapath core.
`timescale 1ns/1ps
module cai_core_tb import cai_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [10:0] avs_address = 11'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  cai_core i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole run needs about eleven hundred cycles; a hang anywhere ends here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rc(input logic [10:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'hF);
    check(rd, e);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    bus(1'b1, CAI_OFS_CMD, {8'h00, b, a, op}, 4'hF);
  endtask

  function automatic logic [10:0] mem(input logic [7:0] i);
    return {1'b1, i, 2'b00};
  endfunction

  task automatic t_reset();
    rc(CAI_OFS_ACC, 32'h00000000);
    rc(CAI_OFS_FLAG, 32'h00000000);
    rc(mem(CAI_ADDR_PTR), 32'h00000000);
    bus(1'b1, CAI_OFS_ACC, 32'h000000FF, 4'h0);
    rc(CAI_OFS_ACC, 32'h00000000);
    rc(11'h010, 32'h00000000);
  endtask

  task automatic t_pointer();
    cmd(CAI_OP_MOV_ID, 8'h25, CAI_ADDR_PTR);
    rc(mem(CAI_ADDR_PTR), 32'h00000025);
    wr(mem(CAI_ADDR_WIN), 32'h0000007E);
    rc(mem(8'h25), 32'h0000007E);
    cmd(CAI_OP_MOV_DD, CAI_ADDR_PTR, 8'h30);
    rc(mem(8'h30), 32'h00000025);
  endtask

  task automatic t_add();
    cmd(CAI_OP_LDA_IMM, 8'hF0, 8'h00);
    cmd(CAI_OP_ADD_IMM, 8'h20, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000010);
    rc(CAI_OFS_FLAG, 32'h00000001);
    wr(mem(8'h0D), 32'h000000F0);
    cmd(8'h2D, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000000);
    rc(CAI_OFS_FLAG, 32'h00000003);
    cmd(CAI_OP_ADC_IMM, 8'h01, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000002);
    cmd(CAI_OP_ADC_DIR, CAI_ADDR_WIN, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000080);
    cmd(CAI_OP_ADC_DIR, CAI_ADDR_PTR, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000A5);
    cmd(8'h2F, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000CA);
    wr(CAI_OFS_FLAG, 32'h00000001);
    cmd(CAI_OP_ADC_IMM, 8'hFF, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000CA);
    rc(CAI_OFS_FLAG, 32'h00000001);
  endtask

  task automatic t_step();
    cmd(8'h0F, 8'h00, 8'h00);
    rc(mem(CAI_ADDR_PTR), 32'h00000026);
    cmd(8'h1F, 8'h00, 8'h00);
    rc(mem(CAI_ADDR_PTR), 32'h00000025);
    cmd(CAI_OP_INC_DIR, CAI_ADDR_WIN, 8'h00);
    rc(mem(8'h25), 32'h0000007F);
    cmd(CAI_OP_DEC_DIR, 8'h80, 8'h00);
    rc(mem(8'h80), 32'h000000FF);
    cmd(CAI_OP_INC_ACC, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000CB);
    cmd(CAI_OP_DEC_ACC, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000CA);
    wr(mem(8'h03), 32'h00000001);
    cmd(8'h13, 8'h00, 8'h00);
    rc(mem(8'h03), 32'h00000000);
    rc(CAI_OFS_FLAG, 32'h00000003);
  endtask

  task automatic t_clear();
    wr(mem(8'h1F), 32'h000000AA);
    cmd(8'h5F, 8'h00, 8'h00);
    rc(mem(8'h1F), 32'h00000000);
    cmd(CAI_OP_CLR_DIR, CAI_ADDR_WIN, 8'h00);
    rc(mem(8'h25), 32'h00000000);
    cmd(CAI_OP_CLR_ACC, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000000);
    cmd(CAI_OP_CLR_DIR, CAI_ADDR_PTR, 8'h00);
    rc(mem(CAI_ADDR_PTR), 32'h00000000);
    wr(CAI_OFS_ACC, 32'h0000005A);
    cmd(8'h9E, 8'h00, 8'h00);
    rc(mem(8'h1E), 32'h0000005A);
  endtask

  // Every code outside the implemented set must leave state alone.
  task automatic t_unimpl();
    for (int op = 8'hB1; op <= 8'hFF; op++) begin
      cmd(op[7:0], 8'h01, 8'h02);
      rc(CAI_OFS_STAT, 32'h00000001);
      wr(CAI_OFS_STAT, 32'h00000001);
    end
    rc(CAI_OFS_STAT, 32'h00000000);
    rc(CAI_OFS_ACC, 32'h0000005A);
    rc(CAI_OFS_FLAG, 32'h00000003);
    rc(mem(8'h02), 32'h00000000);
  endtask

  // Loads, stores and subtraction through the window, pointer, tiny and short forms.
  task automatic t_sub();
    rc(CAI_OFS_CMD, 32'h000201FF);
    cmd(CAI_OP_MOV_ID, 8'h30, CAI_ADDR_PTR);
    rc(mem(CAI_ADDR_WIN), 32'h00000025);
    cmd(CAI_OP_LDA_DIR, CAI_ADDR_WIN, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000025);
    cmd(CAI_OP_SUB_IMM, 8'h26, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000FF);
    rc(CAI_OFS_FLAG, 32'h00000001);
    cmd(CAI_OP_SUB_DIR, CAI_ADDR_PTR, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000CF);
    wr(mem(8'h0C), 32'h000000CF);
    cmd(8'h3C, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h00000000);
    rc(CAI_OFS_FLAG, 32'h00000002);
    cmd(CAI_OP_ADD_DIR, 8'h80, 8'h00);
    rc(CAI_OFS_ACC, 32'h000000FF);
    wr(CAI_OFS_FLAG, 32'h00000003);
    cmd(CAI_OP_STA_DIR, 8'h40, 8'h00);
    rc(mem(8'h40), 32'h000000FF);
    cmd(8'h7E, 8'h00, 8'h00);
    rc(CAI_OFS_ACC, 32'h0000005A);
    rc(CAI_OFS_FLAG, 32'h00000003);
  endtask

  // A reset in mid-run holds waitrequest high and brings every other register and byte back to zero.
  task automatic t_rerst();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h00000000, avs_waitrequest}, 32'h00000001);
    rst_b <= 1'b1;
    rc(mem(CAI_ADDR_PTR), 32'h00000000);
    rc(CAI_OFS_FLAG, 32'h00000000);
    rc(CAI_OFS_CMD, 32'h00000000);
    rc(mem(8'h40), 32'h00000000);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_pointer();
    t_add();
    t_step();
    t_clear();
    t_unimpl();
    t_sub();
    t_rerst();
    results();
  end
endmodule
